// ===== rtc_i2c_slave_with_watchdog_bench.sv
`timescale 1ns/1ps
module rtc_i2c_slave_with_watchdog_bench;
  import rtcw_pkg::*;
  localparam int QTR = 12;
  localparam int LIMIT = 90000;
  logic clk, link_clk, rst;
  logic cmd_valid, cmd_read, cmd_ready, rsp_valid, rsp_nack;
  logic [PTR_W-1:0] cmd_addr, wra1, wra2;
  logic [7:0] cmd_data, rsp_data, wrd1, wrd2;
  logic tick1, tick_o1, frz1, wd1, wrv1;
  logic tick2, tick_o2, frz2, wd2, wrv2;
  logic [11:0] wq[$];
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  int tick_n1 = 0;
  int tick_n2 = 0;
  int wd_n2 = 0;
  int wr_n1 = 0;
  int wd_n1 = 0;
  rtcw_if bus1();
  rtcw_if bus2();
  // host and device on the first bus; second device bit-banged by the bench
  rtcw_host rtcw_host_inst (.CLK_IN(clk), .RST_IN(rst),
    .CMD_VALID_IN(cmd_valid), .CMD_READY_OUT(cmd_ready),
    .CMD_READ_IN(cmd_read), .CMD_ADDR_IN(cmd_addr), .CMD_DATA_IN(cmd_data),
    .RSP_VALID_OUT(rsp_valid), .RSP_DATA_OUT(rsp_data),
    .RSP_NACK_OUT(rsp_nack), .BUS(bus1.mst));
  rtcw_dev rtcw_dev_inst (.CLK_IN(clk), .RST_IN(rst),
    .LINK_CLK_IN(link_clk), .SEC_TICK_IN(tick1), .TICK_OUT(tick_o1),
    .FREEZE_OUT(frz1), .WD_FIRE_OUT(wd1), .WR_VALID_OUT(wrv1),
    .WR_ADDR_OUT(wra1), .WR_DATA_OUT(wrd1), .BUS(bus1.slv));
  rtcw_dev rtcw_dev_inst_b (.CLK_IN(clk), .RST_IN(rst),
    .LINK_CLK_IN(link_clk), .SEC_TICK_IN(tick2), .TICK_OUT(tick_o2),
    .FREEZE_OUT(frz2), .WD_FIRE_OUT(wd2), .WR_VALID_OUT(wrv2),
    .WR_ADDR_OUT(wra2), .WR_DATA_OUT(wrd2), .BUS(bus2.slv));
  rtcw_props rtcw_props_inst (.CLK_IN(clk), .LINK_CLK_IN(link_clk),
    .RST_IN(rst), .m_scl_oe(bus1.m_scl_oe), .m_sda_oe(bus1.m_sda_oe),
    .s_sda_out(bus1.s_sda_out), .s_sda_oe(bus1.s_sda_oe),
    .scl(bus1.scl), .sda(bus1.sda));
  // core clock, and a link clock offset so the phases never line up
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  initial begin
    link_clk = 1'h0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  // event counters and the hang guard
  always @(posedge clk) begin
    cycles++;
    if (tick_o1 === 1'h1) tick_n1++;
    if (tick_o2 === 1'h1) tick_n2++;
    if (wd2 === 1'h1) wd_n2++;
    if (wrv1 === 1'h1) wr_n1++;
    if (wd1 === 1'h1) wd_n1++;
    if (wrv2 === 1'h1) wq.push_back({wra2, wrd2});
    if (cycles == LIMIT) begin
      n_mismatch++;
      $display("[FAIL] run time expected %0d seen %0d", LIMIT, cycles);
      finish_test();
    end
  end
  task automatic chk_bit(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_byte(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // one seconds tick to either device
  task automatic tick(input logic sel);
    @(posedge clk);
    if (sel) tick2 <= 1'h1;
    else tick1 <= 1'h1;
    @(posedge clk);
    tick1 <= 1'h0;
    tick2 <= 1'h0;
  endtask
  // request held until the host is seen ready at an edge
  task automatic host_op(input logic rd, input logic [PTR_W-1:0] a,
                         input logic [7:0] d);
    @(posedge clk);
    cmd_valid <= 1'h1;
    cmd_read <= rd;
    cmd_addr <= a;
    cmd_data <= d;
    @(posedge clk);
    while (cmd_ready !== 1'h1) @(posedge clk);
    cmd_valid <= 1'h0;
    while (rsp_valid !== 1'h1) @(posedge clk);
  endtask
  // one quarter of a serial clock period on the second bus
  task automatic qtr(input logic scl_low, input logic sda_low);
    @(posedge clk);
    bus2.m_scl_oe <= scl_low;
    bus2.m_sda_oe <= sda_low;
    repeat (QTR - 1) @(posedge clk);
  endtask
  task automatic bb_bit(input logic b, output logic s);
    qtr(1'h1, !b);
    qtr(1'h0, !b);
    s = bus2.sda;
    qtr(1'h0, !b);
    qtr(1'h1, !b);
  endtask
  task automatic bb_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bb_bit(d[i], s);
    bb_bit(1'h1, s);
    ack = !s;
  endtask
  task automatic bb_start();
    qtr(1'h0, 1'h0);
    qtr(1'h0, 1'h1);
    qtr(1'h1, 1'h1);
  endtask
  task automatic bb_stop();
    qtr(1'h1, 1'h1);
    qtr(1'h0, 1'h1);
    qtr(1'h0, 1'h0);
  endtask
  task automatic t_reset();
    chk_bit("ready after reset", 1'h1, cmd_ready);
    chk_bit("freeze after reset", 1'h0, frz1);
    chk_bit("clock line idle", 1'h1, bus1.scl);
    chk_bit("data line idle", 1'h1, bus1.sda);
  endtask
  // write then read back, with a seconds tick landing mid-write
  task automatic t_write_read();
    logic [PTR_W-1:0] a[2] = '{4'h3, 4'hf};
    logic [7:0] d[2] = '{8'h5a, 8'ha5};
    for (int i = 0; i < 2; i++) begin
      fork
        host_op(1'h0, a[i], d[i]);
        begin
          wait (frz1 === 1'h1);
          tick(1'h0);
          repeat (4) @(posedge clk);
          chk_byte("held tick", 8'(2 * i), 8'(tick_n1));
        end
      join
      repeat (8) @(posedge clk);
      chk_byte("tick after access", 8'(2 * i + 1), 8'(tick_n1));
      chk_bit("write nack", 1'h0, rsp_nack);
      chk_byte("write addr", {4'h0, a[i]}, {4'h0, wra1});
      chk_byte("write data", d[i], wrd1);
      chk_byte("write reports", 8'(i + 1), 8'(wr_n1));
      host_op(1'h1, a[i], 8'h00);
      chk_byte("read data", d[i], rsp_data);
      chk_bit("read nack", 1'h0, rsp_nack);
      tick(1'h0);
      repeat (3) @(posedge clk);
      chk_byte("idle tick", 8'(2 * i + 2), 8'(tick_n1));
    end
    chk_byte("no early watchdog", 8'h00, 8'(wd_n1));
  endtask
  task automatic t_bad_addr();
    logic ack;
    logic [7:0] bad[2] = '{8'ha4, 8'h53};
    foreach (bad[i]) begin
      bb_start();
      bb_byte(bad[i], ack);
      chk_bit("foreign address ack", 1'h0, ack);
      bb_byte(ADDR_WRITE, ack);
      chk_bit("late address ack", 1'h0, ack);
      chk_bit("freeze on foreign", 1'h0, frz2);
      bb_stop();
    end
  endtask
  // master stalls after the address; two ticks expire the watchdog
  task automatic t_watchdog();
    logic ack;
    bb_start();
    bb_byte(ADDR_WRITE, ack);
    chk_bit("address ack", 1'h1, ack);
    repeat (8) @(posedge clk);
    chk_bit("freeze on access", 1'h1, frz2);
    tick(1'h1);
    repeat (4) @(posedge clk);
    chk_byte("first tick", 8'h00, 8'(tick_n2 + wd_n2));
    tick(1'h1);
    repeat (4) @(posedge clk);
    chk_byte("watchdog fires", 8'h01, 8'(wd_n2));
    chk_byte("one second lost", 8'h01, 8'(tick_n2));
    chk_bit("freeze cleared", 1'h0, frz2);
    repeat (8) @(posedge clk);
    chk_bit("data released", 1'h0, bus2.s_sda_oe);
    // a live access would acknowledge this byte as a word address
    bb_byte(8'h00, ack);
    chk_bit("cleared interface ack", 1'h0, ack);
    bb_stop();
  endtask
  // upper word address bits ignored, pointer steps per data byte
  task automatic t_multi();
    logic ack;
    logic [7:0] b[4] = '{ADDR_WRITE, 8'h35, 8'h11, 8'h22};
    wq.delete();
    bb_start();
    foreach (b[i]) begin
      bb_byte(b[i], ack);
      chk_bit("receiver ack", 1'h1, ack);
    end
    bb_stop();
    repeat (10) @(posedge clk);
    chk_byte("write count", 8'h02, 8'(wq.size()));
    chk_byte("first reg", 8'h05, {4'h0, wq[0][11:8]});
    chk_byte("first data", 8'h11, wq[0][7:0]);
    chk_byte("next reg", 8'h06, {4'h0, wq[1][11:8]});
    chk_byte("next data", 8'h22, wq[1][7:0]);
    chk_bit("freeze after stop", 1'h0, frz2);
  endtask
  initial begin
    rst = 1'h1;
    cmd_valid = 1'h0;
    cmd_read = 1'h0;
    cmd_addr = '0;
    cmd_data = 8'h00;
    tick1 = 1'h0;
    tick2 = 1'h0;
    bus2.m_scl_out = 1'h0;
    bus2.m_sda_out = 1'h0;
    bus2.m_scl_oe = 1'h0;
    bus2.m_sda_oe = 1'h0;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    repeat (10) @(posedge clk);
    t_reset();
    t_write_read();
    t_bad_addr();
    t_watchdog();
    t_multi();
    finish_test();
  end
endmodule

// ===== rtcw_dev.sv
`timescale 1ns/1ps
module rtcw_dev (
  // core clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // link clock, samples the serial bus
  input wire logic LINK_CLK_IN,
  // time base side
  input wire logic SEC_TICK_IN,
  output logic TICK_OUT,
  output logic FREEZE_OUT,
  output logic WD_FIRE_OUT,
  // register write report
  output logic WR_VALID_OUT,
  output logic [rtcw_pkg::PTR_W-1:0] WR_ADDR_OUT,
  output logic [7:0] WR_DATA_OUT,
  // serial bus
  rtcw_if.slv BUS
);
  import rtcw_pkg::*;

  // ---------------- link domain ----------------
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;
  logic wdc_m_q, wdc_s_q, wdc_p_q;
  // watchdog toggle, driven from the core domain below
  logic wd_tgl_q;
  logic scl_rise, scl_fall, start_ev, stop_ev, wd_clear;
  rtcw_dstate_e st_q;
  logic [3:0] cnt_q;
  logic ack_q;
  logic [7:0] sh_q, tx_q;
  logic [PTR_W-1:0] ptr_q;
  logic sda_low_q;
  logic [7:0] mem_q [REG_DEPTH];
  logic wr_tgl_q;
  logic [PTR_W-1:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic busy;

  // sda is only ever pulled low, never driven high
  assign BUS.s_sda_out = 1'b0;
  assign BUS.s_sda_oe = sda_low_q;

  // two-flop synchronisers for the bus pins and the watchdog toggle
  always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
      wdc_m_q <= 1'b0;
      wdc_s_q <= 1'b0;
      wdc_p_q <= 1'b0;
    end else begin
      scl_m_q <= BUS.scl;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= BUS.sda;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
      wdc_m_q <= wd_tgl_q;
      wdc_s_q <= wdc_m_q;
      wdc_p_q <= wdc_s_q;
    end
  end

  // line events; sda moving while scl high is a control condition
  assign scl_rise = scl_s_q & ~scl_p_q;
  assign scl_fall = ~scl_s_q & scl_p_q;
  assign start_ev = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_ev = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  assign wd_clear = wdc_s_q ^ wdc_p_q;
  // an access runs from a matched address to stop, start, master nack on a read, or watchdog
  assign busy = (st_q == DS_WADDR) || (st_q == DS_WDATA) ||
                (st_q == DS_RDATA);

  // protocol engine; reset puts it idle with the pointer cleared
  always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      st_q <= DS_IDLE;
      cnt_q <= 4'h0;
      ack_q <= 1'b0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= PTR_RESET;
      sda_low_q <= 1'b0;
      wr_tgl_q <= 1'b0;
      wr_addr_q <= PTR_RESET;
      wr_data_q <= 8'h00;
      for (int i = 0; i < REG_DEPTH; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else if (wd_clear) begin
      // stuck master: drop the access and let go of the bus
      st_q <= DS_IDLE;
      ack_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (stop_ev) begin
      st_q <= DS_IDLE;
      ack_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (start_ev) begin
      st_q <= DS_ADDR;
      cnt_q <= 4'h0;
      ack_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (st_q != DS_IDLE) begin
      if (scl_rise) begin
        if (!ack_q && cnt_q != BYTE_BITS) begin
          sh_q <= {sh_q[6:0], sda_s_q};
          cnt_q <= cnt_q + 1'b1;
        end else if (ack_q && st_q == DS_RDATA && sda_s_q) begin
          // master did not acknowledge: end of read
          st_q <= DS_IDLE;
        end
      end else if (scl_fall) begin
        if (ack_q) begin
          // acknowledge slot over, next byte begins
          ack_q <= 1'b0;
          cnt_q <= 4'h0;
          if (st_q == DS_RDATA) begin
            tx_q <= mem_q[ptr_q];
            sda_low_q <= ~mem_q[ptr_q][LAST_DATA_BIT[2:0]];
          end else begin
            sda_low_q <= 1'b0;
          end
        end else if (cnt_q == BYTE_BITS) begin
          ack_q <= 1'b1;
          case (st_q)
            DS_ADDR: begin
              if (sh_q == ADDR_WRITE) begin
                st_q <= DS_WADDR;
                sda_low_q <= 1'b1;
              end else if (sh_q == ADDR_READ) begin
                st_q <= DS_RDATA;
                sda_low_q <= 1'b1;
              end else begin
                st_q <= DS_IDLE;
                sda_low_q <= 1'b0;
              end
            end
            DS_WADDR: begin
              ptr_q <= sh_q[PTR_W-1:0];
              st_q <= DS_WDATA;
              sda_low_q <= 1'b1;
            end
            DS_WDATA: begin
              mem_q[ptr_q] <= sh_q;
              wr_addr_q <= ptr_q;
              wr_data_q <= sh_q;
              wr_tgl_q <= ~wr_tgl_q;
              ptr_q <= ptr_q + 1'b1;
              sda_low_q <= 1'b1;
            end
            DS_RDATA: begin
              ptr_q <= ptr_q + 1'b1;
              sda_low_q <= 1'b0;
            end
            default: sda_low_q <= 1'b0;
          endcase
        end else if (st_q == DS_RDATA) begin
          // next data bit goes out while the clock is low
          sda_low_q <= ~tx_q[3'(LAST_DATA_BIT - cnt_q)];
        end
      end
    end
  end

  // ---------------- core domain ----------------
  logic bsy_m_q, bsy_s_q;
  logic wrt_m_q, wrt_s_q, wrt_p_q;
  logic [1:0] wd_cnt_q;
  logic pend_q;
  logic frz_p_q;

  // access level and write toggle cross with two flops
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bsy_m_q <= 1'b0;
      bsy_s_q <= 1'b0;
      wrt_m_q <= 1'b0;
      wrt_s_q <= 1'b0;
      wrt_p_q <= 1'b0;
    end else begin
      bsy_m_q <= busy;
      bsy_s_q <= bsy_m_q;
      wrt_m_q <= wr_tgl_q;
      wrt_s_q <= wrt_m_q;
      wrt_p_q <= wrt_s_q;
    end
  end

  // write report; address and data are held until the next byte
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      WR_VALID_OUT <= 1'b0;
      WR_ADDR_OUT <= PTR_RESET;
      WR_DATA_OUT <= 8'h00;
    end else begin
      WR_VALID_OUT <= wrt_s_q ^ wrt_p_q;
      if (wrt_s_q ^ wrt_p_q) begin
        WR_ADDR_OUT <= wr_addr_q;
        WR_DATA_OUT <= wr_data_q;
      end
    end
  end

  // freeze, watchdog and tick gating
  // at most one tick is held back; the one that fires the
  // watchdog is dropped, so an expiry costs one second
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      FREEZE_OUT <= 1'b0;
      TICK_OUT <= 1'b0;
      WD_FIRE_OUT <= 1'b0;
      wd_tgl_q <= 1'b0;
      wd_cnt_q <= 2'h0;
      pend_q <= 1'b0;
      frz_p_q <= 1'b0;
    end else begin
      TICK_OUT <= 1'b0;
      WD_FIRE_OUT <= 1'b0;
      frz_p_q <= FREEZE_OUT;
      if (!bsy_s_q) begin
        FREEZE_OUT <= 1'b0;
        wd_cnt_q <= 2'h0;
      end else if (!frz_p_q || wd_cnt_q != WD_TICKS) begin
        FREEZE_OUT <= (wd_cnt_q != WD_TICKS);
      end
      if (FREEZE_OUT && SEC_TICK_IN) begin
        if (wd_cnt_q + 1'b1 == WD_TICKS) begin
          wd_cnt_q <= WD_TICKS;
          FREEZE_OUT <= 1'b0;
          WD_FIRE_OUT <= 1'b1;
          wd_tgl_q <= ~wd_tgl_q;
          TICK_OUT <= pend_q;
          pend_q <= 1'b0;
        end else begin
          wd_cnt_q <= wd_cnt_q + 1'b1;
          pend_q <= 1'b1;
        end
      end else if (!FREEZE_OUT) begin
        TICK_OUT <= SEC_TICK_IN | pend_q;
        pend_q <= 1'b0;
      end
    end
  end
endmodule

// ===== rtcw_host.sv
`timescale 1ns/1ps
module rtcw_host (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // command port
  input wire logic CMD_VALID_IN,
  output logic CMD_READY_OUT,
  input wire logic CMD_READ_IN,
  input wire logic [rtcw_pkg::PTR_W-1:0] CMD_ADDR_IN,
  input wire logic [7:0] CMD_DATA_IN,
  // response port
  output logic RSP_VALID_OUT,
  output logic [7:0] RSP_DATA_OUT,
  output logic RSP_NACK_OUT,
  // serial bus
  rtcw_if.mst BUS
);
  import rtcw_pkg::*;

  // which operation a step of a transaction performs
  function automatic rtcw_op_e step_op(input logic rd, input logic [2:0] st);
    rtcw_op_e op;
    op = OP_DONE;
    case (st)
      3'h0: op = OP_START;
      3'h1, 3'h2: op = OP_TX;
      3'h3: op = rd ? OP_START : OP_TX;
      3'h4: op = rd ? OP_TX : OP_STOP;
      3'h5: op = rd ? OP_RX : OP_DONE;
      3'h6: op = rd ? OP_STOP : OP_DONE;
      default: op = OP_DONE;
    endcase
    return op;
  endfunction

  // byte sent at a transmit step
  function automatic logic [7:0] step_byte(input logic rd, input logic [2:0] st,
                                           input logic [7:0] wa,
                                           input logic [7:0] wd);
    logic [7:0] b;
    b = ADDR_WRITE;
    if (st == 3'h2) begin
      b = wa;
    end else if (st == 3'h3) begin
      b = wd;
    end else if (st == 3'h4) begin
      b = ADDR_READ;
    end
    return b;
  endfunction

  logic sda_m_q, sda_s_q;
  logic busy_q;
  logic rd_q;
  logic [7:0] wa_q, wd_q, sh_q;
  logic [2:0] step_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [QTR_W-1:0] qc_q;
  logic scl_low_q, sda_low_q, nack_q;
  logic tick;
  rtcw_op_e op;
  logic [7:0] cur_byte;

  assign tick = busy_q && (qc_q == QTR_LAST);
  assign op = step_op(rd_q, step_q);
  assign cur_byte = step_byte(rd_q, step_q, wa_q, wd_q);
  assign CMD_READY_OUT = ~busy_q;
  assign BUS.m_scl_out = 1'b0;
  assign BUS.m_sda_out = 1'b0;
  assign BUS.m_scl_oe = scl_low_q;
  assign BUS.m_sda_oe = sda_low_q;

  // bus pin crosses into this clock domain
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else begin
      sda_m_q <= BUS.sda;
      sda_s_q <= sda_m_q;
    end
  end

  // quarter-period divider, source of the serial clock
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      qc_q <= '0;
    end else if (!busy_q || tick) begin
      qc_q <= '0;
    end else begin
      qc_q <= qc_q + 1'b1;
    end
  end

  // transaction sequencer and line drivers
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      busy_q <= 1'b0;
      rd_q <= 1'b0;
      wa_q <= 8'h00;
      wd_q <= 8'h00;
      sh_q <= 8'h00;
      step_q <= 3'h0;
      ph_q <= PH_SET;
      bit_q <= 4'h0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      nack_q <= 1'b0;
      RSP_VALID_OUT <= 1'b0;
      RSP_DATA_OUT <= 8'h00;
      RSP_NACK_OUT <= 1'b0;
    end else begin
      RSP_VALID_OUT <= 1'b0;
      if (!busy_q) begin
        if (CMD_VALID_IN) begin
          busy_q <= 1'b1;
          rd_q <= CMD_READ_IN;
          wa_q <= {4'h0, CMD_ADDR_IN};
          wd_q <= CMD_DATA_IN;
          step_q <= 3'h0;
          ph_q <= PH_SET;
          bit_q <= 4'h0;
          nack_q <= 1'b0;
        end
      end else if (tick) begin
        ph_q <= ph_q + 1'b1;
        case (op)
          OP_START: begin
            // sda released, clock high, sda falls, clock low
            case (ph_q)
              PH_SET: sda_low_q <= 1'b0;
              PH_RISE: scl_low_q <= 1'b0;
              PH_SAMPLE: sda_low_q <= 1'b1;
              default: begin
                scl_low_q <= 1'b1;
                step_q <= step_q + 1'b1;
              end
            endcase
          end
          OP_TX, OP_RX: begin
            case (ph_q)
              PH_SET: begin
                // data changes only while the clock is low
                if (bit_q == BYTE_BITS) begin
                  sda_low_q <= 1'b0;
                end else if (op == OP_TX) begin
                  sda_low_q <= ~cur_byte[3'(LAST_DATA_BIT - bit_q)];
                end else begin
                  sda_low_q <= 1'b0;
                end
              end
              PH_RISE: scl_low_q <= 1'b0;
              PH_SAMPLE: begin
                if (bit_q != BYTE_BITS) begin
                  sh_q <= {sh_q[6:0], sda_s_q};
                end else if (op == OP_TX && sda_s_q) begin
                  nack_q <= 1'b1;
                end
              end
              default: begin
                scl_low_q <= 1'b1;
                if (bit_q == BYTE_BITS) begin
                  bit_q <= 4'h0;
                  if (op == OP_TX && nack_q) begin
                    step_q <= rd_q ? STEP_STOP_RD : STEP_STOP_WR;
                  end else begin
                    step_q <= step_q + 1'b1;
                  end
                end else begin
                  bit_q <= bit_q + 1'b1;
                end
              end
            endcase
          end
          OP_STOP: begin
            case (ph_q)
              PH_SET: sda_low_q <= 1'b1;
              PH_RISE: scl_low_q <= 1'b0;
              PH_SAMPLE: sda_low_q <= 1'b0;
              default: step_q <= step_q + 1'b1;
            endcase
          end
          default: begin
            busy_q <= 1'b0;
            RSP_VALID_OUT <= 1'b1;
            RSP_DATA_OUT <= sh_q;
            RSP_NACK_OUT <= nack_q;
          end
        endcase
      end
    end
  end
endmodule

// ===== rtcw_if.sv
`timescale 1ns/1ps
interface rtcw_if;
  // host drives
  logic m_scl_out;
  logic m_scl_oe;
  logic m_sda_out;
  logic m_sda_oe;
  // device drives
  logic s_sda_out;
  logic s_sda_oe;
  // resolved wire levels, pulled up when nobody pulls low
  logic scl;
  logic sda;

  assign scl = ~(m_scl_oe & ~m_scl_out);
  assign sda = ~((m_sda_oe & ~m_sda_out) | (s_sda_oe & ~s_sda_out));

  modport mst (
    output m_scl_out, m_scl_oe, m_sda_out, m_sda_oe,
    input sda
  );
  modport slv (
    output s_sda_out, s_sda_oe,
    input scl, sda
  );
endinterface

// ===== rtcw_pkg.sv
package rtcw_pkg;
  // slave addresses on the wire
  localparam logic [7:0] ADDR_WRITE = 8'ha2;
  localparam logic [7:0] ADDR_READ = 8'ha3;
  // register pointer and register file size
  localparam int unsigned PTR_W = 4;
  localparam int unsigned REG_DEPTH = 16;
  localparam logic [PTR_W-1:0] PTR_RESET = 4'h0;
  // bit counting: eight data bits, then the acknowledge slot
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  // watchdog: fires on the second seconds tick after a valid address
  localparam logic [1:0] WD_TICKS = 2'h2;
  // host bus timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned SCL_HZ = 400_000;
  localparam int unsigned QTR_CYC = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
  localparam int unsigned QTR_W = 7;
  localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYC - 1);
  // bit phases within one quarter-divided serial clock period
  localparam logic [1:0] PH_SET = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;
  // host sequencer steps
  localparam logic [2:0] STEP_STOP_WR = 3'h4;
  localparam logic [2:0] STEP_STOP_RD = 3'h6;

  // device protocol states
  typedef enum logic [2:0] {
    DS_IDLE,
    DS_ADDR,
    DS_WADDR,
    DS_WDATA,
    DS_RDATA
  } rtcw_dstate_e;

  // host bus operations
  typedef enum logic [2:0] {
    OP_START,
    OP_TX,
    OP_RX,
    OP_STOP,
    OP_DONE
  } rtcw_op_e;
endpackage

// ===== rtcw_props.sv
`timescale 1ns/1ps
module rtcw_props (
  // clocks and reset
  input wire logic CLK_IN,
  input wire logic LINK_CLK_IN,
  input wire logic RST_IN,
  // bus drivers and resolved wires
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic s_sda_out,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q;
  logic sda_q;
  logic [3:0] rise_q;
  logic start_w;
  logic stop_w;
  logic rise_w;
  // line events seen in the core domain
  assign start_w = scl && scl_q && sda_q && !sda;
  assign stop_w = scl && scl_q && !sda_q && sda;
  assign rise_w = scl && !scl_q;
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // clock rises since start; saturates so long reads stay quiet
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rise_q <= 4'h0;
    end else if (start_w) begin
      rise_q <= 4'h0;
    end else if (rise_w && rise_q != 4'hf) begin
      rise_q <= rise_q + 4'h1;
    end
  end
  property p_reset_release;
    @(posedge CLK_IN) disable iff (RST_IN)
    $fell(RST_IN) |-> !m_scl_oe && !m_sda_oe && !s_sda_oe;
  endproperty
  a_reset_release: assert property (p_reset_release)
    else $error("lines not released after reset");
  property p_drive_low;
    @(posedge LINK_CLK_IN) disable iff (RST_IN) s_sda_oe |-> !s_sda_out;
  endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("device drives data line high");
  property p_quiet_high;
    @(posedge LINK_CLK_IN) disable iff (RST_IN)
    scl && $past(scl) |-> $stable(s_sda_oe);
  endproperty
  a_quiet_high: assert property (p_quiet_high)
    else $error("device changed data while clock high");
  property p_prompt;
    @(posedge LINK_CLK_IN) disable iff (RST_IN)
    $changed(s_sda_oe) |-> !scl && $past(scl, 8);
  endproperty
  a_prompt: assert property (p_prompt)
    else $error("device data change not just after clock fall");
  property p_ack_hold;
    @(posedge CLK_IN) disable iff (RST_IN) rise_w && s_sda_oe |-> !sda [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("data line not held low in high phase");
  property p_addr_ack;
    @(posedge CLK_IN) disable iff (RST_IN)
    rise_w && rise_q == 4'h8 |-> s_sda_oe;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("address byte not acknowledged");
  property p_addr_listen;
    @(posedge CLK_IN) disable iff (RST_IN)
    rise_w && rise_q < 4'h8 |-> !s_sda_oe;
  endproperty
  a_addr_listen: assert property (p_addr_listen)
    else $error("device drove during address bits");
  property p_stop_idle;
    @(posedge CLK_IN) disable iff (RST_IN)
    stop_w |-> (!s_sda_oe && !m_scl_oe) [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("bus not idle after stop");
  property p_start_src;
    @(posedge CLK_IN) disable iff (RST_IN) start_w |-> m_sda_oe && !s_sda_oe;
  endproperty
  a_start_src: assert property (p_start_src)
    else $error("start not made by the master");
  // main scenarios reached
  c_start: cover property (@(posedge CLK_IN) disable iff (RST_IN) start_w);
  c_stop: cover property (@(posedge CLK_IN) disable iff (RST_IN) stop_w);
  c_ack: cover property (@(posedge CLK_IN) disable iff (RST_IN)
    rise_w && rise_q == 4'h8 && s_sda_oe);
endmodule
